// >>> hdl/sfr_pkg.sv
// Notes on behaviour
// - regulator undervoltage holds reset, loses init
// - reset faults: silent on bus, switch opened
// - short cap dip, no selftest: flags 0,0,1
// - short cap dip, selftest: flags 0,1,1
// - cap recovery before period keeps configuration
// - long cap dip resets every cap period
// - cap test failure resets every test period
// - bus low past timeout resets every timeout
// - factory array crc fault: error 1, short zero
// - user array mismatch: error 1, short zero
// - selftest enabled: flags 1,1,0, selftest data
// - two disable commands with no other command between them enter selftest lockout
// - clear command or reset ends lockout
// - cap dip, regulator or timeout ends lockout
// - error flag shows memory fault, or enabled selftest without cap dip
package sfr_pkg;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SWITCH_OPEN_TIME_NS = 1000;
  localparam int unsigned SWITCH_OPEN_CYC = SWITCH_OPEN_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CAP_RESET_PERIOD_US = 1000;
  localparam int unsigned CAP_TEST_RESET_PERIOD_US = 1000;
  localparam int unsigned FRAME_TIMEOUT_PERIOD_US = 1000;
  localparam int unsigned HOLD_CAP_RESET_CYC = HOLD_CAP_RESET_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CAP_TEST_RESET_CYC = CAP_TEST_RESET_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RESET_PULSE_CYC = 4;
  localparam int unsigned CNT_W = 24;

  // ********************************************************************
  // status register layout
  // ********************************************************************
  localparam int unsigned EV_W = 6;
  localparam int unsigned EV_REG_UV = 0;
  localparam int unsigned EV_CAP_LONG = 1;
  localparam int unsigned EV_CAP_TEST = 2;
  localparam int unsigned EV_TIMEOUT = 3;
  localparam int unsigned EV_OTP = 4;
  localparam int unsigned EV_LOCKOUT = 5;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h3;
  localparam logic [EV_W-1:0] IRQ_EN_RST = 6'h00;

  typedef enum logic [1:0] {
    SFR_RUN,
    SFR_HOLD,
    SFR_PULSE
  } sfr_state_t;

endpackage

// >>> hdl/sfr_period_timer.sv
`timescale 1ns/1ps
// counts while a fault persists; pulses at each period, repeatedly
module sfr_period_timer #(
  parameter int unsigned PERIOD = 100
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic active,
  output logic      expire
);

  typedef struct packed {
    logic [sfr_pkg::CNT_W-1:0] cnt;
    logic                      exp;
  } sfr_tmr_t;

  sfr_tmr_t st_r;
  sfr_tmr_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.exp = 1'b0;
    if (!active)
    begin
      st_nxt.cnt = '0;
    end
    else if (st_r.cnt == sfr_pkg::CNT_W'(PERIOD - 1))
    begin
      st_nxt.cnt = '0;
      st_nxt.exp = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign expire = st_r.exp;

endmodule

// >>> hdl/sfr_top.sv
`timescale 1ns/1ps
module sfr_top #(
  parameter int unsigned HOLD_CAP_CYC  = sfr_pkg::HOLD_CAP_RESET_CYC,
  parameter int unsigned CAP_TEST_CYC  = sfr_pkg::CAP_TEST_RESET_CYC,
  parameter int unsigned TIMEOUT_CYC   = sfr_pkg::FRAME_TIMEOUT_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        DIGITAL_REGULATOR_UV,
  input  wire logic        ANALOG_REGULATOR_UV,
  input  wire logic        HOLD_CAP_LOW,
  input  wire logic        CAP_TEST_FAIL,
  input  wire logic        UPSTREAM_BUS_LOW,
  input  wire logic        FACTORY_CRC_FAIL,
  input  wire logic        FACTORY_LOCK,
  input  wire logic        USER_MISMATCH,
  input  wire logic        USER_LOCK,
  input  wire logic        CMD_ENABLE_SELFTEST,
  input  wire logic        CMD_DISABLE_SELFTEST,
  input  wire logic        CMD_OTHER,
  input  wire logic        CMD_CLEAR,
  input  wire logic        SWITCH_CLOSE_REQ,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [7:0]       REG_RDATA,
  output logic             IRQ,
  output logic             CORE_RESET_N,
  output logic             BUS_RESPONSE_EN,
  output logic             BUS_SWITCH_STATE,
  output logic             SELFTEST_DRIVE,
  output logic             ERROR_FLAG,
  output logic             SELFTEST_ACTIVE_FLAG,
  output logic             CAP_LOW_FLAG,
  output logic             SHORT_ACCEL_ZERO,
  output logic             SHORT_ACCEL_SELFTEST,
  output logic             LONG_ACCEL_SELFTEST
);

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    sfr_pkg::sfr_state_t           fsm;
    logic [2:0]                    pulse_cnt;
    logic                          init_lost;
    logic                          st_en;
    logic                          lockout;
    logic                          last_dis;
    logic                          sw_closed;
    logic [sfr_pkg::EV_W-1:0]      irq_stat;
    logic [sfr_pkg::EV_W-1:0]      irq_en;
    logic [7:0]                    rdata;
    logic                          err;
    logic                          stf;
    logic                          capf;
    logic                          sz;
    logic                          sst;
    logic                          lst;
  } sfr_state_s_t;

  sfr_state_s_t s_r;
  sfr_state_s_t s_nxt;

  logic reg_uv;
  logic cap_exp;
  logic test_exp;
  logic to_exp;
  logic repeat_rst;
  logic otp_fault;
  logic [sfr_pkg::EV_W-1:0] ev;

  // ********************************************************************
  // repeating reset timers
  // ********************************************************************
  sfr_period_timer #(.PERIOD(HOLD_CAP_CYC)) u_cap_tmr (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .active  (HOLD_CAP_LOW & ~reg_uv),
    .expire  (cap_exp)
  );
  sfr_period_timer #(.PERIOD(CAP_TEST_CYC)) u_test_tmr (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .active  (CAP_TEST_FAIL & ~reg_uv),
    .expire  (test_exp)
  );
  sfr_period_timer #(.PERIOD(TIMEOUT_CYC)) u_to_tmr (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .active  (UPSTREAM_BUS_LOW & ~reg_uv),
    .expire  (to_exp)
  );

  function automatic logic [7:0] rd_mux(input logic [3:0] a, input sfr_state_s_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      sfr_pkg::ADDR_STATUS:   v = {2'b00, s.lockout, s.st_en, s.err, s.stf, s.capf, s.init_lost};
      sfr_pkg::ADDR_IRQ_STAT: v = {2'b00, s.irq_stat};
      sfr_pkg::ADDR_IRQ_EN:   v = {2'b00, s.irq_en};
      default:                v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb
  begin
    reg_uv     = DIGITAL_REGULATOR_UV | ANALOG_REGULATOR_UV;
    repeat_rst = cap_exp | test_exp | to_exp;
    otp_fault  = (FACTORY_CRC_FAIL & FACTORY_LOCK) | (USER_MISMATCH & USER_LOCK);
    ev         = '0;
    ev[sfr_pkg::EV_REG_UV]   = reg_uv;
    ev[sfr_pkg::EV_CAP_LONG] = cap_exp;
    ev[sfr_pkg::EV_CAP_TEST] = test_exp;
    ev[sfr_pkg::EV_TIMEOUT]  = to_exp;
    ev[sfr_pkg::EV_OTP]      = otp_fault;
    ev[sfr_pkg::EV_LOCKOUT]  = CMD_DISABLE_SELFTEST & s_r.last_dis & ~s_r.lockout;
    s_nxt = s_r;

    // ******************************************************************
    // reset sequencing
    // ******************************************************************
    case (s_r.fsm)
      sfr_pkg::SFR_RUN:
      begin
        if (reg_uv)
        begin
          s_nxt.fsm = sfr_pkg::SFR_HOLD;
        end
        else if (repeat_rst)
        begin
          s_nxt.fsm       = sfr_pkg::SFR_PULSE;
          s_nxt.pulse_cnt = '0;
        end
      end
      sfr_pkg::SFR_HOLD:
      begin
        if (!reg_uv)
        begin
          s_nxt.fsm = sfr_pkg::SFR_RUN;
        end
      end
      sfr_pkg::SFR_PULSE:
      begin
        if (reg_uv)
        begin
          s_nxt.fsm = sfr_pkg::SFR_HOLD;
        end
        else if (s_r.pulse_cnt == 3'(sfr_pkg::RESET_PULSE_CYC - 1))
        begin
          s_nxt.fsm = sfr_pkg::SFR_RUN;
        end
        else
        begin
          s_nxt.pulse_cnt = s_r.pulse_cnt + 3'h1;
        end
      end
      default:
      begin
        s_nxt.fsm = sfr_pkg::SFR_RUN;
      end
    endcase

    // ******************************************************************
    // self-test and lockout
    // ******************************************************************
    if (s_nxt.fsm != sfr_pkg::SFR_RUN || s_r.fsm != sfr_pkg::SFR_RUN)
    begin
      s_nxt.init_lost = 1'b1;
      s_nxt.st_en     = 1'b0;
      s_nxt.lockout   = 1'b0;
      s_nxt.last_dis  = 1'b0;
      s_nxt.sw_closed = 1'b0;
    end
    else
    begin
      if (CMD_CLEAR)
      begin
        s_nxt.lockout   = 1'b0;
        s_nxt.init_lost = 1'b0;
        s_nxt.st_en     = 1'b0;
        s_nxt.last_dis  = 1'b0;
      end
      else if (CMD_DISABLE_SELFTEST)
      begin
        s_nxt.st_en    = 1'b0;
        s_nxt.last_dis = 1'b1;
        if (s_r.last_dis)
        begin
          s_nxt.lockout = 1'b1;
        end
      end
      else if (CMD_ENABLE_SELFTEST)
      begin
        s_nxt.last_dis = 1'b0;
        s_nxt.st_en    = ~s_r.lockout;
      end
      else if (CMD_OTHER)
      begin
        s_nxt.last_dis = 1'b0;
      end
      if (HOLD_CAP_LOW)
      begin
        s_nxt.lockout = 1'b0;
      end
      if (SWITCH_CLOSE_REQ)
      begin
        s_nxt.sw_closed = 1'b1;
      end
    end

    // ******************************************************************
    // status flags and data substitution
    // ******************************************************************
    s_nxt.err  = otp_fault | s_nxt.st_en;
    s_nxt.stf  = s_nxt.st_en;
    s_nxt.capf = HOLD_CAP_LOW & ~otp_fault & ~s_nxt.st_en;
    if (HOLD_CAP_LOW & ~otp_fault)
    begin
      s_nxt.err  = 1'b0;
      s_nxt.capf = 1'b1;
    end
    s_nxt.sz  = ~s_nxt.st_en & (HOLD_CAP_LOW | otp_fault)
              | s_nxt.st_en & otp_fault;
    s_nxt.sst = s_nxt.st_en & ~otp_fault;
    s_nxt.lst = s_nxt.st_en;

    // ******************************************************************
    // register port and interrupts
    // ******************************************************************
    s_nxt.irq_stat = s_r.irq_stat;
    if (REG_WR && REG_ADDR == sfr_pkg::ADDR_IRQ_CLR)
    begin
      s_nxt.irq_stat = s_r.irq_stat & ~REG_WDATA[sfr_pkg::EV_W-1:0];
    end
    if (REG_WR && REG_ADDR == sfr_pkg::ADDR_IRQ_EN)
    begin
      s_nxt.irq_en = REG_WDATA[sfr_pkg::EV_W-1:0];
    end
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
    s_nxt.rdata    = REG_RD ? rd_mux(REG_ADDR, s_r) : 8'h00;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      s_r           <= '0;
      s_r.fsm       <= sfr_pkg::SFR_RUN;
      s_r.init_lost <= 1'b1;
      s_r.irq_en    <= sfr_pkg::IRQ_EN_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign CORE_RESET_N         = (s_r.fsm == sfr_pkg::SFR_RUN);
  assign BUS_RESPONSE_EN      = (s_r.fsm == sfr_pkg::SFR_RUN);
  assign BUS_SWITCH_STATE     = s_r.sw_closed;
  assign SELFTEST_DRIVE       = s_r.st_en;
  assign ERROR_FLAG           = s_r.err;
  assign SELFTEST_ACTIVE_FLAG = s_r.stf;
  assign CAP_LOW_FLAG         = s_r.capf;
  assign SHORT_ACCEL_ZERO     = s_r.sz;
  assign SHORT_ACCEL_SELFTEST = s_r.sst;
  assign LONG_ACCEL_SELFTEST  = s_r.lst;
  assign REG_RDATA            = s_r.rdata;
  assign IRQ                  = |(s_r.irq_stat & s_r.irq_en);

endmodule

// >>> sim/sfr_properties.sv
`timescale 1ns/1ps
module sfr_properties #(
  parameter int unsigned HOLD_CAP_CYC = 20
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic DIGITAL_REGULATOR_UV,
  input wire logic ANALOG_REGULATOR_UV,
  input wire logic HOLD_CAP_LOW,
  input wire logic FACTORY_CRC_FAIL,
  input wire logic FACTORY_LOCK,
  input wire logic USER_MISMATCH,
  input wire logic USER_LOCK,
  input wire logic CMD_ENABLE_SELFTEST,
  input wire logic CMD_DISABLE_SELFTEST,
  input wire logic CMD_OTHER,
  input wire logic CMD_CLEAR,
  input wire logic CORE_RESET_N,
  input wire logic BUS_RESPONSE_EN,
  input wire logic BUS_SWITCH_STATE,
  input wire logic SELFTEST_DRIVE,
  input wire logic ERROR_FLAG,
  input wire logic SELFTEST_ACTIVE_FLAG,
  input wire logic CAP_LOW_FLAG,
  input wire logic SHORT_ACCEL_ZERO,
  input wire logic LONG_ACCEL_SELFTEST
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  logic        otp;
  logic        uv;
  logic [23:0] cap_cnt_r;
  logic [23:0] cap_cnt_nxt;
  logic        dis_seen_r;
  logic        locked_r;
  assign otp = (FACTORY_CRC_FAIL && FACTORY_LOCK) || (USER_MISMATCH && USER_LOCK);
  assign uv = DIGITAL_REGULATOR_UV || ANALOG_REGULATOR_UV;
  assign cap_cnt_nxt = HOLD_CAP_LOW ? cap_cnt_r + 24'h1 : 24'h0;
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      cap_cnt_r <= 24'h0;
    else
      cap_cnt_r <= cap_cnt_nxt;
  end
  // lockout expected from the command history, cap low and reset
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N || !CORE_RESET_N || CMD_CLEAR)
    begin
      dis_seen_r <= 1'b0;
      locked_r   <= 1'b0;
    end
    else
    begin
      if (CMD_DISABLE_SELFTEST)
        dis_seen_r <= 1'b1;
      else if (CMD_ENABLE_SELFTEST || CMD_OTHER)
        dis_seen_r <= 1'b0;
      if (HOLD_CAP_LOW)
        locked_r <= 1'b0;
      else if (CMD_DISABLE_SELFTEST && dis_seen_r)
        locked_r <= 1'b1;
    end
  end
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  // ****************************************************************
  // properties
  // ****************************************************************
  sequence cap_only;
    HOLD_CAP_LOW && !otp && CORE_RESET_N;
  endsequence
  sequence otp_on;
    otp && CORE_RESET_N;
  endsequence
  sequence lock_en;
    locked_r && CMD_ENABLE_SELFTEST && CORE_RESET_N && !HOLD_CAP_LOW;
  endsequence
  reg_uv_hold_a: assert property (uv |=> !CORE_RESET_N)
    else $error("core not held in reset under regulator undervoltage");
  resp_silent_a: assert property (BUS_RESPONSE_EN == CORE_RESET_N && (CORE_RESET_N || !BUS_SWITCH_STATE))
    else $error("bus response enabled during reset");
  switch_open_a: assert property ($fell(CORE_RESET_N) |-> ##[0:1] !BUS_SWITCH_STATE)
    else $error("bus switch not opened on reset");
  pulse_len_a: assert property ($fell(CORE_RESET_N) && !uv |-> (!CORE_RESET_N)[*4] ##1 CORE_RESET_N)
    else $error("reset pulse length wrong");
  cap_period_a: assert property (cap_cnt_r == 24'(HOLD_CAP_CYC) && !uv |-> ##[0:3] !CORE_RESET_N)
    else $error("no reset after hold cap period");
  cap_dip_a: assert property (cap_only ##1 cap_only ##1 cap_only |-> CAP_LOW_FLAG && !ERROR_FLAG && SHORT_ACCEL_ZERO == !SELFTEST_ACTIVE_FLAG)
    else $error("cap dip flags wrong");
  otp_fault_a: assert property (otp_on ##1 otp_on ##1 otp_on |-> ERROR_FLAG && !CAP_LOW_FLAG && SHORT_ACCEL_ZERO)
    else $error("memory fault flags wrong");
  st_flags_a: assert property (SELFTEST_DRIVE && !$past(HOLD_CAP_LOW) |-> SELFTEST_ACTIVE_FLAG && LONG_ACCEL_SELFTEST && ERROR_FLAG && !CAP_LOW_FLAG)
    else $error("selftest flags wrong");
  lockout_a: assert property (lock_en |=> !SELFTEST_DRIVE && !SELFTEST_ACTIVE_FLAG)
    else $error("selftest enabled in lockout");
endmodule
bind sfr_top sfr_properties #(.HOLD_CAP_CYC(HOLD_CAP_CYC)) u_sfr_properties (
  .REF_CLK, .RESET_N, .DIGITAL_REGULATOR_UV, .ANALOG_REGULATOR_UV, .HOLD_CAP_LOW,
  .FACTORY_CRC_FAIL, .FACTORY_LOCK, .USER_MISMATCH, .USER_LOCK, .CMD_ENABLE_SELFTEST,
  .CMD_DISABLE_SELFTEST, .CMD_OTHER, .CMD_CLEAR, .CORE_RESET_N, .BUS_RESPONSE_EN,
  .BUS_SWITCH_STATE,
  .SELFTEST_DRIVE, .ERROR_FLAG, .SELFTEST_ACTIVE_FLAG, .CAP_LOW_FLAG,
  .SHORT_ACCEL_ZERO, .LONG_ACCEL_SELFTEST);

// >>> sim/sfr_master_model.sv
`timescale 1ns/1ps
module sfr_master_model (
  input  wire logic clk,
  input  wire logic core_reset_n,
  input  wire logic init_req,
  output logic      cmd_clear,
  output logic      switch_close
);
  logic core_q;
  initial
  begin
    core_q = 1'b1;
    cmd_clear = 1'b0;
    switch_close = 1'b0;
  end
  // clear then close switch whenever the device comes back
  // a short cap dip keeps the core up, so no re-init follows
  always @(posedge clk)
  begin
    core_q <= core_reset_n;
    cmd_clear <= init_req || (core_reset_n === 1'b1 && core_q === 1'b0);
    switch_close <= cmd_clear;
  end
endmodule

// >>> sim/sfr_tb_top.sv
`timescale 1ns/1ps
module sfr_tb_top;
  localparam int unsigned PER = 20;
  localparam logic [3:0] EN = 4'h8, DIS = 4'h4, OTH = 4'h2, INI = 4'h1;
  logic REF_CLK, RESET_N, DIGITAL_REGULATOR_UV, ANALOG_REGULATOR_UV, HOLD_CAP_LOW;
  logic CAP_TEST_FAIL, UPSTREAM_BUS_LOW, FACTORY_CRC_FAIL, FACTORY_LOCK, USER_MISMATCH;
  logic USER_LOCK, CMD_ENABLE_SELFTEST, CMD_DISABLE_SELFTEST, CMD_OTHER, CMD_CLEAR;
  logic SWITCH_CLOSE_REQ, REG_WR, REG_RD, IRQ, CORE_RESET_N, BUS_RESPONSE_EN;
  logic BUS_SWITCH_STATE, SELFTEST_DRIVE, ERROR_FLAG, SELFTEST_ACTIVE_FLAG, CAP_LOW_FLAG;
  logic SHORT_ACCEL_ZERO, SHORT_ACCEL_SELFTEST, LONG_ACCEL_SELFTEST, init_req;
  logic [3:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA;
  int         error_cnt, checks, falls, lows;
  logic       prev_en;
  sfr_top #(.HOLD_CAP_CYC(PER), .CAP_TEST_CYC(PER), .TIMEOUT_CYC(PER)) u_sfr_top (
    .REF_CLK, .RESET_N, .DIGITAL_REGULATOR_UV, .ANALOG_REGULATOR_UV, .HOLD_CAP_LOW,
    .CAP_TEST_FAIL, .UPSTREAM_BUS_LOW, .FACTORY_CRC_FAIL, .FACTORY_LOCK, .USER_MISMATCH,
    .USER_LOCK, .CMD_ENABLE_SELFTEST, .CMD_DISABLE_SELFTEST, .CMD_OTHER, .CMD_CLEAR,
    .SWITCH_CLOSE_REQ, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .IRQ,
    .CORE_RESET_N, .BUS_RESPONSE_EN, .BUS_SWITCH_STATE, .SELFTEST_DRIVE, .ERROR_FLAG,
    .SELFTEST_ACTIVE_FLAG, .CAP_LOW_FLAG, .SHORT_ACCEL_ZERO, .SHORT_ACCEL_SELFTEST,
    .LONG_ACCEL_SELFTEST);
  sfr_master_model u_sfr_master_model (.clk(REF_CLK), .core_reset_n(CORE_RESET_N),
    .init_req, .cmd_clear(CMD_CLEAR), .switch_close(SWITCH_CLOSE_REQ));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [7:0] fl();
    return {2'h0, ERROR_FLAG, SELFTEST_ACTIVE_FLAG, CAP_LOW_FLAG, SHORT_ACCEL_ZERO,
            SHORT_ACCEL_SELFTEST, LONG_ACCEL_SELFTEST};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic cmd(input logic [3:0] c);
    @(posedge REF_CLK);
    {CMD_ENABLE_SELFTEST, CMD_DISABLE_SELFTEST, CMD_OTHER, init_req} <= c;
    @(posedge REF_CLK);
    {CMD_ENABLE_SELFTEST, CMD_DISABLE_SELFTEST, CMD_OTHER, init_req} <= 4'h0;
    cyc(3);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge REF_CLK);
    {REG_RD, REG_ADDR} <= {1'b1, a};
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    #1;
    chk(n, REG_RDATA, e);
  endtask
  task automatic set_inputs(input logic [8:0] v);
    @(posedge REF_CLK);
    {DIGITAL_REGULATOR_UV, ANALOG_REGULATOR_UV, HOLD_CAP_LOW, CAP_TEST_FAIL, UPSTREAM_BUS_LOW,
     FACTORY_CRC_FAIL, FACTORY_LOCK, USER_MISMATCH, USER_LOCK} <= v;
    cyc(3);
  endtask
  task automatic results;
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_dip;
    set_inputs(9'h040);
    cyc(PER - 8);
    chk("dip flags", fl(), 8'h0c);
    set_inputs(9'h000);
    chk("dip switch", {7'h0, BUS_SWITCH_STATE & CORE_RESET_N}, 8'h01);
    rc("dip status", 4'h0, 8'h00);
  endtask
  task automatic t_selftest;
    cmd(EN);
    chk("st flags", fl(), 8'h33);
    chk("st drive", {7'h0, SELFTEST_DRIVE}, 8'h01);
    set_inputs(9'h040);
    chk("st dip flags", fl(), 8'h1b);
    set_inputs(9'h00c);
    chk("st factory", fl(), 8'h35);
    set_inputs(9'h003);
    chk("st user", fl(), 8'h35);
    cmd(DIS);
    chk("user", fl(), 8'h24);
    set_inputs(9'h00c);
    chk("factory", fl(), 8'h24);
    set_inputs(9'h000);
    chk("idle", fl(), 8'h00);
  endtask
  task automatic t_lockout;
    cmd(OTH);
    cmd(DIS);
    cmd(OTH);
    cmd(DIS);
    cmd(EN);
    chk("no lock", {7'h0, SELFTEST_DRIVE}, 8'h01);
    cmd(DIS);
    cmd(DIS);
    cmd(EN);
    chk("locked", fl(), 8'h00);
    rc("lock status", 4'h0, 8'h20);
    cmd(INI);
    cmd(EN);
    chk("clear unlock", {7'h0, SELFTEST_DRIVE}, 8'h01);
    cmd(DIS);
    cmd(DIS);
    set_inputs(9'h040);
    set_inputs(9'h000);
    cmd(EN);
    chk("cap unlock", {7'h0, SELFTEST_DRIVE}, 8'h01);
    cmd(DIS);
    cmd(DIS);
  endtask
  task automatic t_faults;
    for (int i = 0; i < 5; i++)
    begin
      falls = 0;
      lows = 0;
      prev_en = 1'b1;
      set_inputs(9'h100 >> i);
      repeat (50)
      begin
        lows += !BUS_RESPONSE_EN;
        falls += (prev_en && !BUS_RESPONSE_EN);
        prev_en = BUS_RESPONSE_EN;
        cyc(1);
      end
      set_inputs(9'h000);
      cyc(10);
      if (i > 1)
      begin
        chk("silent cycles", 8'(lows), 8'h08);
        chk("reset repeats", 8'(falls), 8'h02);
      end
      else
        chk("held cycles", 8'(lows > 45), 8'h01);
      chk("reinit switch", {7'h0, BUS_SWITCH_STATE}, 8'h01);
    end
    cmd(EN);
    chk("reset unlock", {7'h0, SELFTEST_DRIVE}, 8'h01);
  endtask
  task automatic t_irq;
    rc("irq stat", 4'h1, 8'h3f);
    chk("irq masked", {7'h0, IRQ}, 8'h00);
    wr(4'h2, 8'h01);
    cyc(1);
    chk("irq raised", {7'h0, IRQ}, 8'h01);
    wr(4'h3, 8'h3f);
    rc("irq cleared", 4'h1, 8'h00);
    chk("irq low", {7'h0, IRQ}, 8'h00);
    rc("irq en", 4'h2, 8'h01);
    rc("unmapped", 4'hf, 8'h00);
  endtask
  initial
  begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    error_cnt++;
    results();
  end
  initial
  begin
    {RESET_N, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = 15'h0;
    {CMD_ENABLE_SELFTEST, CMD_DISABLE_SELFTEST, CMD_OTHER, init_req} = 4'h0;
    {DIGITAL_REGULATOR_UV, ANALOG_REGULATOR_UV, HOLD_CAP_LOW, CAP_TEST_FAIL} = 4'h0;
    {UPSTREAM_BUS_LOW, FACTORY_CRC_FAIL, FACTORY_LOCK, USER_MISMATCH, USER_LOCK} = 5'h0;
    repeat (5) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    cmd(INI);
    t_dip();
    t_selftest();
    t_lockout();
    t_faults();
    t_irq();
    results();
  end
endmodule
